// [logic/kbhcp_pkg.sv]
// constants and types shared by the host command port design
`default_nettype none

package kbhcp_pkg;

  // host i/o addresses
  localparam logic [7:0] ADDR_DATA = 8'h60;
  localparam logic [7:0] ADDR_CMD  = 8'h64;

  // status register bit positions
  localparam int ST_OBF = 0;
  localparam int ST_IBF = 1;
  localparam int ST_SYS = 2;
  localparam int ST_CD  = 3;
  localparam int ST_INH = 4;
  localparam int ST_AUX = 5;

  // controller config byte bit positions
  localparam int CB_KIRQ = 1 - 1;
  localparam int CB_MIRQ = 1;
  localparam int CB_SYS  = 2;
  localparam int CB_KDIS = 4;
  localparam int CB_MDIS = 5;
  localparam int CB_XLAT = 6;
  localparam int CB_RSV  = 7;

  // config byte reset value and write masks
  localparam logic [7:0] CB_RESET   = 8'h00;
  localparam logic [7:0] CB_MASK_KB = 8'h7D;
  localparam logic [7:0] CB_MASK_PS = 8'h7F;

  // command codes and range limits
  localparam logic [7:0] CMD_RD_CB   = 8'h20;
  localparam logic [7:0] CMD_WR_CB   = 8'h60;
  localparam logic [7:0] CMD_RD_TOP  = 8'h40;
  localparam logic [7:0] CMD_WR_TOP  = 8'h80;
  localparam logic [7:0] CMD_ROM     = 8'hA0;
  localparam logic [7:0] CMD_VER     = 8'hA1;
  localparam logic [7:0] CMD_PW_TEST = 8'hA4;
  localparam logic [7:0] CMD_PW_LOAD = 8'hA5;
  localparam logic [7:0] CMD_PW_EN   = 8'hA6;
  localparam logic [7:0] CMD_M_OFF   = 8'hA7;

  // reply bytes
  localparam logic [7:0] RESP_PW_YES = 8'hFA;
  localparam logic [7:0] RESP_PW_NO  = 8'hF1;
  localparam logic [7:0] VERSION     = 8'h3C; // arbitrary value
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  // scan code translation
  localparam logic [7:0] XLAT_BREAK = 8'hF0;
  localparam logic [7:0] XLAT_REL   = 8'h80;

  // shared memory: ram window then password window
  localparam int         MEM_AW    = 7;
  localparam int         MEM_DEPTH = 128;
  localparam logic [1:0] PW_BANK   = 2'h2;
  localparam logic [4:0] PW_MAX    = 5'h10;
  localparam logic [4:0] PW_ONE    = 5'h01;

  // controller states, one-hot
  typedef enum logic [4:0] {
    KBHCP_IDLE  = 5'b00001,
    KBHCP_RAMRD = 5'b00010,
    KBHCP_RESP  = 5'b00100,
    KBHCP_ROM   = 5'b01000,
    KBHCP_PWCHK = 5'b10000
  } kbhcp_state_t;

  // what the next data byte is for
  typedef enum logic [1:0] {
    KBHCP_P_RAM = 2'h0,
    KBHCP_P_CB  = 2'h1,
    KBHCP_P_PW  = 2'h2
  } kbhcp_param_t;

  // rom readout, zero terminated; contents arbitrary
  function automatic logic [7:0] kbhcp_rom_byte(input logic [3:0] i);
    case (i)
      4'h0:    return 8'h4B;
      4'h1:    return 8'h42;
      4'h2:    return 8'h43;
      default: return 8'h00;
    endcase
  endfunction

endpackage

`default_nettype wire

// [logic/kbhcp_mem_if.sv]
// port between the controller and its byte memory
`default_nettype none

interface kbhcp_mem_if;
  logic [kbhcp_pkg::MEM_AW-1:0] addr;
  logic                         we;
  logic [7:0]                   wdata;
  logic [7:0]                   rdata;
  modport ctl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface

`default_nettype wire

// [logic/kbhcp_mem.sv]
// byte memory for internal ram and the password stream
`default_nettype none

module kbhcp_mem (
  input  wire logic   ref_clk_in,
  input  wire logic   rst_in,
  kbhcp_mem_if.mem    port
);

  typedef struct packed {
    logic [kbhcp_pkg::MEM_DEPTH-1:0][7:0] arr;
    logic [7:0]                           rdata;
  } kbhcp_mem_st_t;

  kbhcp_mem_st_t s_q;
  kbhcp_mem_st_t s_d;

  // write through port, read data registered
  always_comb begin
    s_d = s_q;
    s_d.rdata = s_q.arr[port.addr];
    if (port.we) begin
      s_d.arr[port.addr] = port.wdata;
    end
  end

  // contents cleared at reset so reads are defined
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign port.rdata = s_q.rdata;

endmodule

`default_nettype wire

// [logic/kbhcp_top.sv]
// host command port of the keyboard and mouse controller
//
// Notes on behaviour
// R1: 8-bit write-only input buffer, host writes at 60h or 64h.
// R2: write sets a data flag at 60h, command flag at 64h.
// R3: data byte goes to keyboard unless a command awaits its parameter.
// R4: host writes only while input buffer full reads 0.
// R5: 8-bit read-only output buffer at 60h carries scan codes and replies.
// R6: host reads output buffer only while output buffer full reads 1.
// R7: commands 00-1F and 21-3F load the addressed ram byte for reading.
// R8: command 20 loads the current config byte for reading.
// R9: commands 40-5F and 61-7F store next data byte into ram.
// R10: command 60 stores next data byte into the config byte.
// R11: config bit 0 raises interrupt whenever keyboard data is loaded.
// R12: config bit 1 enables mouse interrupt in ps2 mode, else held 0.
// R13: config system flag is mirrored into status bit 2.
// R14: config bit 4 holds keyboard clock low, no keyboard traffic; code blocks only received bytes, host data bytes still go out.
// R15: config bit 5 holds mouse clock low, no mouse traffic.
// R16: config bit 6 translates scan codes, folding break pairs; bit 7 zero.
// R17: command A0 streams rom bytes ending with a zero byte.
// R18: command A1 loads the version code for reading.
// R19: A4 clears reg B; ps2 mode replies FA if password set, else F1.
// R20: A5 clears reg B; ps2 mode stores up to 16 password bytes.
// R21: A6 reads reg B; ps2 mode withholds keys until password typed.
// R22: A7 clears reg C; ps2 mode disables mouse, clock held low.
// R23: read-only status at 64h, bit 0 output full, bit 1 input full.
// R24: status bit 3 is 1 after a 64h write, 0 after 60h.
// R25: input full sets on write, clears on consume; output full likewise.
`default_nettype none

module kbhcp_top (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       ps2_mode_in,
  input  wire logic       io_wr_in,
  input  wire logic       io_rd_in,
  input  wire logic [7:0] io_addr_in,
  input  wire logic [7:0] io_wdata_in,
  output logic      [7:0] io_rdata_out,
  input  wire logic       kbd_rx_valid_in,
  input  wire logic [7:0] kbd_rx_data_in,
  output logic            kbd_rx_ready_out,
  input  wire logic       mouse_rx_valid_in,
  input  wire logic [7:0] mouse_rx_data_in,
  output logic            mouse_rx_ready_out,
  output logic            kbd_tx_valid_out,
  output logic      [7:0] kbd_tx_data_out,
  output logic            kbd_clk_low_out,
  output logic            mouse_clk_low_out,
  output logic            kbd_irq_out,
  output logic            mouse_irq_out
);

  // whole controller state
  typedef struct packed {
    kbhcp_pkg::kbhcp_state_t st;
    logic [7:0]              ib;
    logic                    ibf;
    logic                    cd;
    logic [7:0]              obuf;
    logic                    obf;
    logic                    aux;
    logic [7:0]              cb;
    logic                    pend;
    kbhcp_pkg::kbhcp_param_t kind;
    logic [5:0]              ram_adr;
    logic [7:0]              reg_b;
    logic [7:0]              reg_c;
    logic                    mouse_off;
    logic [4:0]              pw_len;
    logic [4:0]              pw_idx;
    logic                    locked;
    logic [7:0]              pwb;
    logic                    brk;
    logic [7:0]              rb;
    logic [3:0]              rom_idx;
    logic [7:0]              rdata;
    logic                    tx_valid;
    logic [7:0]              tx_data;
    logic                    kready;
    logic                    mready;
    logic                    kclk_low;
    logic                    mclk_low;
    logic                    kirq;
    logic                    mirq;
  } kbhcp_regs_t;

  kbhcp_regs_t q;
  kbhcp_regs_t n;

  kbhcp_mem_if mif ();

  kbhcp_mem u_mem (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .port       (mif.mem)
  );

  // memory address of one password byte
  function automatic logic [kbhcp_pkg::MEM_AW-1:0] pw_addr(
    input logic [4:0] idx
  );
    return {kbhcp_pkg::PW_BANK, idx};
  endfunction

  // status byte as the host sees it at 64h
  function automatic logic [7:0] status_of(input kbhcp_regs_t s);
    logic [7:0] v;
    v = '0;
    v[kbhcp_pkg::ST_OBF] = s.obf;                       // [R23]
    v[kbhcp_pkg::ST_IBF] = s.ibf;                       // [R23]
    v[kbhcp_pkg::ST_SYS] = s.cb[kbhcp_pkg::CB_SYS];     // [R13]
    v[kbhcp_pkg::ST_CD]  = s.cd;                        // [R24]
    v[kbhcp_pkg::ST_INH] = 1'b1;
    v[kbhcp_pkg::ST_AUX] = s.aux;
    return v;
  endfunction

  logic       rx_k;
  logic       rx_m;
  logic       pw_set;
  logic [7:0] kb;
  logic [7:0] c;

  assign rx_k   = kbd_rx_valid_in && q.kready;
  assign rx_m   = mouse_rx_valid_in && q.mready && !rx_k;
  assign pw_set = (q.pw_len != '0);

  // next state of the whole controller
  always_comb begin
    n = q;
    n.tx_valid = 1'b0;
    mif.addr = '0;
    mif.we = 1'b0;
    mif.wdata = q.ib;
    c = q.ib;
    kb = kbd_rx_data_in;
    if (q.brk) begin
      kb = kbd_rx_data_in | kbhcp_pkg::XLAT_REL;      // [R16]
    end

    // host read: status at 64h, output buffer at 60h
    if (io_rd_in) begin
      if (io_addr_in == kbhcp_pkg::ADDR_CMD) begin
        n.rdata = status_of(q);                        // [R23]
      end else if (io_addr_in == kbhcp_pkg::ADDR_DATA) begin
        n.rdata = q.obuf;                              // [R5]
        n.obf = 1'b0;                                  // [R25]
      end
    end

    case (q.st)
      kbhcp_pkg::KBHCP_IDLE: begin
        if (rx_k) begin
          if (q.cb[kbhcp_pkg::CB_XLAT] && !q.brk &&
              kbd_rx_data_in == kbhcp_pkg::XLAT_BREAK) begin
            n.brk = 1'b1;                              // [R16]
          end else begin
            n.brk = 1'b0;
            if (q.locked) begin
              mif.addr = pw_addr(q.pw_idx);            // [R21]
              n.pwb = kb;
              n.st = kbhcp_pkg::KBHCP_PWCHK;
            end else begin
              n.obuf = kb;                             // [R5]
              n.obf = 1'b1;                            // [R25]
              n.aux = 1'b0;
            end
          end
        end else if (rx_m) begin
          n.obuf = mouse_rx_data_in;                   // [R5]
          n.obf = 1'b1;                                // [R25]
          n.aux = 1'b1;
        end else if (q.ibf) begin
          n.ibf = 1'b0;                                // [R25]
          if (q.cd) begin
            // a new command drops any pending parameter
            n.pend = 1'b0;
            if (c == kbhcp_pkg::CMD_RD_CB) begin
              n.rb = q.cb;                             // [R8]
              n.st = kbhcp_pkg::KBHCP_RESP;
            end else if (c < kbhcp_pkg::CMD_RD_TOP) begin
              mif.addr = {1'b0, c[5:0]};               // [R7]
              n.st = kbhcp_pkg::KBHCP_RAMRD;
            end else if (c == kbhcp_pkg::CMD_WR_CB) begin
              n.pend = 1'b1;                           // [R10]
              n.kind = kbhcp_pkg::KBHCP_P_CB;
            end else if (c < kbhcp_pkg::CMD_WR_TOP) begin
              n.pend = 1'b1;                           // [R9]
              n.kind = kbhcp_pkg::KBHCP_P_RAM;
              n.ram_adr = c[5:0];
            end else if (c == kbhcp_pkg::CMD_ROM) begin
              n.rom_idx = '0;                          // [R17]
              n.st = kbhcp_pkg::KBHCP_ROM;
            end else if (c == kbhcp_pkg::CMD_VER) begin
              n.rb = kbhcp_pkg::VERSION;               // [R18]
              n.st = kbhcp_pkg::KBHCP_RESP;
            end else if (c == kbhcp_pkg::CMD_PW_TEST) begin
              if (ps2_mode_in) begin
                n.rb = pw_set ? kbhcp_pkg::RESP_PW_YES
                              : kbhcp_pkg::RESP_PW_NO; // [R19]
                n.st = kbhcp_pkg::KBHCP_RESP;
              end else begin
                n.reg_b = '0;                          // [R19]
              end
            end else if (c == kbhcp_pkg::CMD_PW_LOAD) begin
              if (ps2_mode_in) begin
                n.pend = 1'b1;                         // [R20]
                n.kind = kbhcp_pkg::KBHCP_P_PW;
                n.pw_len = '0;
                n.locked = 1'b0;
              end else begin
                n.reg_b = '0;                          // [R20]
              end
            end else if (c == kbhcp_pkg::CMD_PW_EN) begin
              if (ps2_mode_in) begin
                n.locked = pw_set;                     // [R21]
                n.pw_idx = '0;
              end else begin
                n.rb = q.reg_b;                        // [R21]
                n.st = kbhcp_pkg::KBHCP_RESP;
              end
            end else if (c == kbhcp_pkg::CMD_M_OFF) begin
              if (ps2_mode_in) begin
                n.mouse_off = 1'b1;                    // [R22]
              end else begin
                n.reg_c = '0;                          // [R22]
              end
            end
          end else if (q.pend) begin
            // data byte is the parameter of the last command
            case (q.kind)
              kbhcp_pkg::KBHCP_P_RAM: begin
                mif.addr = {1'b0, q.ram_adr};          // [R9]
                mif.we = 1'b1;
                n.pend = 1'b0;
              end
              kbhcp_pkg::KBHCP_P_CB: begin
                n.cb = q.ib & (ps2_mode_in ? kbhcp_pkg::CB_MASK_PS
                                           : kbhcp_pkg::CB_MASK_KB);
                n.pend = 1'b0;                         // [R10] [R12]
              end
              default: begin
                if (q.ib == kbhcp_pkg::BYTE_ZERO) begin
                  n.pend = 1'b0;                       // [R20]
                end else begin
                  mif.addr = pw_addr(q.pw_len);        // [R20]
                  mif.we = 1'b1;
                  n.pw_len = q.pw_len + kbhcp_pkg::PW_ONE;
                  if (n.pw_len == kbhcp_pkg::PW_MAX) begin
                    n.pend = 1'b0;
                  end
                end
              end
            endcase
          end else begin
            n.tx_valid = 1'b1;                         // [R3]
            n.tx_data = q.ib;
          end
        end
      end

      // ram byte arrives one cycle after its address
      kbhcp_pkg::KBHCP_RAMRD: begin
        n.rb = mif.rdata;                              // [R7]
        n.st = kbhcp_pkg::KBHCP_RESP;
      end

      // reply waits for an empty output buffer
      kbhcp_pkg::KBHCP_RESP: begin
        if (!n.obf) begin
          n.obuf = q.rb;
          n.obf = 1'b1;                                // [R25]
          n.aux = 1'b0;
          n.st = kbhcp_pkg::KBHCP_IDLE;
        end
      end

      // rom bytes one per emptied buffer, zero ends it
      kbhcp_pkg::KBHCP_ROM: begin
        if (!n.obf) begin
          n.obuf = kbhcp_pkg::kbhcp_rom_byte(q.rom_idx); // [R17]
          n.obf = 1'b1;
          n.aux = 1'b0;
          n.rom_idx = q.rom_idx + 4'h1;
          if (n.obuf == kbhcp_pkg::BYTE_ZERO) begin
            n.st = kbhcp_pkg::KBHCP_IDLE;
          end
        end
      end

      // typed key against stored password byte
      kbhcp_pkg::KBHCP_PWCHK: begin
        if (mif.rdata == q.pwb) begin
          if (q.pw_idx + kbhcp_pkg::PW_ONE == q.pw_len) begin
            n.locked = 1'b0;                           // [R21]
            n.pw_idx = '0;
          end else begin
            n.pw_idx = q.pw_idx + kbhcp_pkg::PW_ONE;
          end
        end else begin
          n.pw_idx = '0;
        end
        n.st = kbhcp_pkg::KBHCP_IDLE;
      end

      default: begin
        n.st = kbhcp_pkg::KBHCP_IDLE;
      end
    endcase

    // host write lands last so it beats a same-cycle consume
    if (io_wr_in && (io_addr_in == kbhcp_pkg::ADDR_DATA ||
                     io_addr_in == kbhcp_pkg::ADDR_CMD)) begin
      n.ib = io_wdata_in;                              // [R1]
      n.ibf = 1'b1;                                    // [R25]
      n.cd = (io_addr_in == kbhcp_pkg::ADDR_CMD);      // [R2] [R24]
    end

    // registered pin levels derived from next state
    n.kclk_low = n.cb[kbhcp_pkg::CB_KDIS];             // [R14]
    n.mclk_low = n.cb[kbhcp_pkg::CB_MDIS] | n.mouse_off; // [R15] [R22]
    n.kready = (n.st == kbhcp_pkg::KBHCP_IDLE) && !n.obf && !n.ibf &&
               !n.cb[kbhcp_pkg::CB_KDIS];              // [R14]
    n.mready = (n.st == kbhcp_pkg::KBHCP_IDLE) && !n.obf && !n.ibf &&
               ps2_mode_in && !n.mclk_low;             // [R15]
    n.kirq = n.obf && !n.aux && n.cb[kbhcp_pkg::CB_KIRQ]; // [R11]
    n.mirq = n.obf && n.aux && ps2_mode_in &&
             n.cb[kbhcp_pkg::CB_MIRQ];                 // [R12]
  end

  // state register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q <= '0;
      q.st <= kbhcp_pkg::KBHCP_IDLE;
      q.cb <= kbhcp_pkg::CB_RESET;
    end else begin
      q <= n;
    end
  end

  // outputs straight from the state register
  assign io_rdata_out       = q.rdata;
  assign kbd_rx_ready_out   = q.kready;
  assign mouse_rx_ready_out = q.mready;
  assign kbd_tx_valid_out   = q.tx_valid;
  assign kbd_tx_data_out    = q.tx_data;
  assign kbd_clk_low_out    = q.kclk_low;
  assign mouse_clk_low_out  = q.mclk_low;
  assign kbd_irq_out        = q.kirq;
  assign mouse_irq_out      = q.mirq;

endmodule

`default_nettype wire

// [dv/kbhcp_properties.sv]
// assertion checker bound to the host command port top
`default_nettype none

module kbhcp_properties (
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  input wire logic       ps2_mode_in,
  input wire logic       io_wr_in,
  input wire logic       io_rd_in,
  input wire logic [7:0] io_addr_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic       kbd_rx_valid_in,
  input wire logic       kbd_rx_ready_out,
  input wire logic       mouse_rx_valid_in,
  input wire logic       mouse_rx_ready_out,
  input wire logic       kbd_tx_valid_out,
  input wire logic       kbd_clk_low_out,
  input wire logic       mouse_clk_low_out,
  input wire logic       kbd_irq_out,
  input wire logic       mouse_irq_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  // host write to either mapped address
  logic wr_hit;
  assign wr_hit = io_wr_in && (io_addr_in == kbhcp_pkg::ADDR_DATA ||
                               io_addr_in == kbhcp_pkg::ADDR_CMD);

  // forwarded keyboard byte
  chk_tx_one_pulse: assert property (
    kbd_tx_valid_out |=> !kbd_tx_valid_out)
    else $error("keyboard send strobe too wide");
  chk_tx_after_wr: assert property (
    $rose(kbd_tx_valid_out) |->
      $past(io_wr_in && io_addr_in == kbhcp_pkg::ADDR_DATA, 2))
    else $error("keyboard send without a data write");
  // disabled ports take nothing
  chk_kdis_no_rx: assert property (
    kbd_clk_low_out |-> !kbd_rx_ready_out)
    else $error("keyboard ready while disabled");
  chk_mdis_no_rx: assert property (
    mouse_clk_low_out |-> !mouse_rx_ready_out)
    else $error("mouse ready while disabled");
  // full buffers close the receivers
  chk_take_blocks: assert property (
    mouse_rx_valid_in && mouse_rx_ready_out |->
      ##1 !kbd_rx_ready_out && !mouse_rx_ready_out)
    else $error("receive open with output full");
  chk_wr_blocks: assert property (wr_hit |-> ##1 !kbd_rx_ready_out)
    else $error("receive open with input full");
  // interrupts follow their source
  chk_kirq_cause: assert property (
    $rose(kbd_irq_out) |->
      !$past(mouse_rx_valid_in && mouse_rx_ready_out && !kbd_rx_valid_in))
    else $error("keyboard interrupt raised by a mouse byte");
  chk_mirq_mode: assert property (mouse_irq_out |-> $past(ps2_mode_in))
    else $error("mouse interrupt outside mouse mode");
  // read data moves only on a read
  chk_rdata_hold: assert property (
    !$past(io_rd_in) && !$past(io_rd_in, 2) |-> $stable(io_rdata_out))
    else $error("read data changed without a read");
endmodule

bind kbhcp_top kbhcp_properties i_props (
  .ref_clk_in, .rst_in, .ps2_mode_in, .io_wr_in, .io_rd_in, .io_addr_in,
  .io_rdata_out, .kbd_rx_valid_in, .kbd_rx_ready_out, .mouse_rx_valid_in,
  .mouse_rx_ready_out, .kbd_tx_valid_out, .kbd_clk_low_out,
  .mouse_clk_low_out, .kbd_irq_out, .mouse_irq_out
);

`default_nettype wire

// [dv/kbhcp_host_model.sv]
// host processor model driving the controller's i/o strobes
`default_nettype none

module kbhcp_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic            wr_out,
  output logic            rd_out,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap = 0; // idle cycles before each access

  // bus idle at time zero
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end

  // one strobe cycle, then lines scrambled so nothing stale is seen
  task automatic access(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
    repeat (gap + 1) @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = w;
    rd_out = !w;
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
    @(negedge clk_in);
    q = rdata_in;
  endtask

  // poll status until bit b reads v, bounded
  task automatic poll(input int b, input logic v, output bit ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 64 && !ok; i++) begin
      access(1'b0, kbhcp_pkg::ADDR_CMD, 8'h00, s);
      ok = (s[b] === v);
    end
  endtask

  // write once input is empty, read once output is full
  task automatic write(input logic [7:0] a, d, output bit ok);
    logic [7:0] q;
    poll(kbhcp_pkg::ST_IBF, 1'b0, ok);
    access(1'b1, a, d, q);
  endtask
  task automatic read(output logic [7:0] q, output bit ok);
    poll(kbhcp_pkg::ST_OBF, 1'b1, ok);
    access(1'b0, kbhcp_pkg::ADDR_DATA, 8'h00, q);
  endtask
endmodule

`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for the host command port
`default_nettype none
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); \
  end \
end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ps2 = 1'b1;
  logic       kv = 1'b0;
  logic       mv = 1'b0;
  logic [7:0] rxd = 8'h00;
  logic       wr, rd, txv, kclk, mclk, kirq, mirq, krdy, mrdy;
  logic [7:0] addr, wdata, rdata, txd;
  int         num_errors = 0;
  int         tests_run = 0;
  int         ram[64];
  logic [7:0] txq[$];
  logic [7:0] rom[4] = '{8'h4B, 8'h42, 8'h43, 8'h00};
  logic [7:0] pw[3] = '{8'h12, 8'h34, 8'h00};
  logic [7:0] key[3] = '{8'h77, 8'h12, 8'h34};
  logic [7:0] kcmd[2] = '{8'hA4, 8'hA5};
  int         slot[4] = '{0, 31, 33, 63};

  // 200 MHz clock
  always #2.5 clk = ~clk;

  kbhcp_top i_dut (
    .ref_clk_in(clk), .rst_in(rst), .ps2_mode_in(ps2), .io_wr_in(wr),
    .io_rd_in(rd), .io_addr_in(addr), .io_wdata_in(wdata),
    .io_rdata_out(rdata), .kbd_rx_valid_in(kv), .kbd_rx_data_in(rxd),
    .kbd_rx_ready_out(krdy), .mouse_rx_valid_in(mv),
    .mouse_rx_data_in(rxd), .mouse_rx_ready_out(mrdy),
    .kbd_tx_valid_out(txv), .kbd_tx_data_out(txd),
    .kbd_clk_low_out(kclk), .mouse_clk_low_out(mclk),
    .kbd_irq_out(kirq), .mouse_irq_out(mirq)
  );
  kbhcp_host_model host (
    .clk_in(clk), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
    .addr_out(addr), .wdata_out(wdata)
  );

  // record bytes sent to the keyboard
  always @(negedge clk) begin
    if (txv === 1'b1) txq.push_back(txd);
  end

  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // status read without waiting on a flag
  task automatic stat(output logic [7:0] s);
    host.access(1'b0, kbhcp_pkg::ADDR_CMD, 8'h00, s);
  endtask
  // host write, then the command/data flag in status
  task automatic put(input logic [7:0] a, d);
    bit ok;
    logic [7:0] s;
    host.write(a, d, ok);
    stat(s);
    `CHK(ok, 1'b1)
    `CHK(s[kbhcp_pkg::ST_CD], a == kbhcp_pkg::ADDR_CMD)
  endtask
  task automatic cmd(input logic [7:0] c);
    put(kbhcp_pkg::ADDR_CMD, c);
  endtask
  task automatic dat(input logic [7:0] d);
    put(kbhcp_pkg::ADDR_DATA, d);
  endtask
  task automatic cfg(input logic [7:0] d);
    cmd(kbhcp_pkg::CMD_WR_CB);
    dat(d);
  endtask
  // read one output byte and compare with the model
  task automatic get(input logic [7:0] e);
    bit ok;
    logic [7:0] q;
    host.read(q, ok);
    `CHK(ok, 1'b1)
    `CHK(q, e)
  endtask
  // offer one byte from keyboard (m=0) or mouse (m=1) until taken
  task automatic rx(input bit m, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk); // one idle step between offers
    kv = !m;
    mv = m;
    rxd = d;
    while (n < 200 && (m ? mrdy : krdy) !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    kv = 1'b0;
    mv = 1'b0;
    rxd = ~d;
    `CHK(n < 200, 1'b1)
  endtask

  // main sequence
  initial begin
    logic [7:0] v, e;
    int a;
    void'($urandom(28925));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    stat(v);
    `CHK(v, 8'h10)
    // config byte round trip in both modes, mirrored to status and pins
    for (int i = 0; i < 6; i++) begin
      ps2 = i[0];
      host.gap = $urandom_range(3);
      v = 8'($urandom);
      e = v & (ps2 ? kbhcp_pkg::CB_MASK_PS : kbhcp_pkg::CB_MASK_KB);
      cfg(v);
      cmd(kbhcp_pkg::CMD_RD_CB);
      get(e);
      stat(v);
      `CHK(v[kbhcp_pkg::ST_SYS], e[kbhcp_pkg::CB_SYS])
      `CHK(kclk, e[kbhcp_pkg::CB_KDIS])
      `CHK(mclk, e[kbhcp_pkg::CB_MDIS])
    end
    `CHK(txq.size(), 0)
    // ram slots: cleared value, write, read back
    ps2 = 1'b1;
    for (int i = 0; i < 8; i++) begin
      a = (i < 4) ? slot[i] : $urandom_range(63);
      if (a == 32) a = 33;
      cmd(8'(a));
      get(8'(ram[a]));
      ram[a] = $urandom_range(255);
      cmd(8'(64 + a));
      dat(8'(ram[a]));
      cmd(8'(a));
      get(8'(ram[a]));
    end
    // version and rom stream
    cmd(kbhcp_pkg::CMD_VER);
    get(kbhcp_pkg::VERSION);
    cmd(kbhcp_pkg::CMD_ROM);
    foreach (rom[k]) get(rom[k]);
    stat(v);
    `CHK(v[kbhcp_pkg::ST_OBF], 1'b0)
    // plain data goes to the keyboard; unmapped address ignored
    v = 8'($urandom);
    dat(v);
    e = txq.pop_front();
    `CHK(e, v)
    stat(e);
    host.access(1'b1, 8'h61, 8'h5A, v);
    host.access(1'b0, 8'h61, 8'h00, v);
    `CHK(v, e)
    `CHK(txq.size(), 0)
    // password stored, tested, enforced
    cmd(kbhcp_pkg::CMD_PW_TEST);
    get(8'hF1);
    cmd(kbhcp_pkg::CMD_PW_LOAD);
    foreach (pw[k]) dat(pw[k]);
    cmd(kbhcp_pkg::CMD_PW_TEST);
    get(8'hFA);
    cfg(8'h01);
    cmd(kbhcp_pkg::CMD_PW_EN);
    foreach (key[k]) rx(1'b0, key[k]);
    stat(v);
    `CHK(v[kbhcp_pkg::ST_OBF], 1'b0)
    rx(1'b0, 8'h55);
    `CHK(kirq, 1'b1)
    get(8'h55);
    `CHK(kirq, 1'b0)
    // break prefix folded into the next code
    cfg(8'h41);
    rx(1'b0, 8'hF0);
    stat(v);
    `CHK(v[kbhcp_pkg::ST_OBF], 1'b0)
    rx(1'b0, 8'h1C);
    get(8'h9C);
    // mouse byte with its interrupt
    cfg(8'h02);
    rx(1'b1, 8'h5A);
    stat(v);
    `CHK(mirq, 1'b1)
    `CHK(v[kbhcp_pkg::ST_AUX], 1'b1)
    get(8'h5A);
    // plain keyboard mode register commands, then mouse disable
    ps2 = 1'b0;
    foreach (kcmd[k]) begin
      cmd(kcmd[k]);
      cmd(kbhcp_pkg::CMD_PW_EN);
      get(8'h00);
    end
    cmd(kbhcp_pkg::CMD_M_OFF);
    `CHK(mclk, 1'b0)
    ps2 = 1'b1;
    cmd(kbhcp_pkg::CMD_M_OFF);
    `CHK(mclk, 1'b1)
    final_report();
  end

  // cut a hung run short
  initial begin
    #300000;
    num_errors++;
    final_report();
  end
endmodule

`default_nettype wire
